//--- rss_sequencer.sv
// Rail strobe sequencer: gap and slot registers, strobe stepping, buck rail enables
`timescale 1ns/10ps
`include "rss_cfg.svh"
module rss_sequencer import rss_pkg::*; #(
    parameter int unsigned P_SHORT_CYC = `RSS_GAP_SHORT_MS * `RSS_CLK_KHZ,
    parameter int unsigned P_LONG_CYC = `RSS_GAP_LONG_MS * `RSS_CLK_KHZ
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_power_on,
    input wire logic i_unlocked,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_first_buck_rail_en,
    output logic o_second_buck_rail_en,
    output logic o_first_buck_seq_ctl,
    output logic o_second_buck_seq_ctl,
    output logic o_strobe_pulse,
    output logic [3:0] o_strobe_num,
    output logic o_seq_busy
);
    localparam int unsigned PD_FACTOR = `RSS_PD_FACTOR;

    logic rst_meta;
    logic rst_n;
    logic pwr_meta;
    logic pwr_on;
    logic [7:0] strobe_gap_select_low;
    logic [7:0] strobe_gap_select_high;
    logic [7:0] buck_rail_slot_assign;
    logic [8:0] gap_sel;
    logic powerdown_gap_multiplier;
    rss_slot_t slot [2];
    logic [1:0] slot_ok;
    logic [1:0] rail_en;
    rss_state_t state;
    rss_state_t next_state;
    logic [3:0] next_strobe;
    logic strobe_fire;
    logic gap_load;
    logic [3:0] gap_idx;
    logic [31:0] gap_cyc;
    logic gap_done;
    logic wr_ok;
    logic [7:0] next_rdata;

    // Reset release and power request synchronisers
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_meta <= 1'b0;
            pwr_on <= 1'b0;
        end else begin
            pwr_meta <= i_power_on;
            pwr_on <= pwr_meta;
        end
    end

    // Register writes
    assign wr_ok = i_reg_wr && i_unlocked; // see R14

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_gap_select_low <= `RSS_RST_GAP_LOW; // see R12
        end else if (wr_ok && i_reg_addr == `RSS_ADDR_GAP_LOW) begin
            strobe_gap_select_low <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_gap_select_high <= `RSS_RST_GAP_HIGH; // see R12
        end else if (wr_ok && i_reg_addr == `RSS_ADDR_GAP_HIGH) begin
            strobe_gap_select_high <= 8'h00; // see R6
            strobe_gap_select_high[`RSS_BIT_PD_MULT] <= i_reg_wdata[`RSS_BIT_PD_MULT];
            strobe_gap_select_high[`RSS_BIT_GAP_NINE] <= i_reg_wdata[`RSS_BIT_GAP_NINE];
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            buck_rail_slot_assign <= `RSS_RST_SLOT; // see R11
        end else if (wr_ok && i_reg_addr == `RSS_ADDR_SLOT) begin
            buck_rail_slot_assign <= i_reg_wdata;
        end
    end

    // Register read, one cycle after the address
    always_comb begin
        case (i_reg_addr)
            `RSS_ADDR_GAP_LOW: next_rdata = strobe_gap_select_low;
            `RSS_ADDR_GAP_HIGH: next_rdata = strobe_gap_select_high;
            `RSS_ADDR_SLOT: next_rdata = buck_rail_slot_assign;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_rdata <= next_rdata;
        end
    end

    // Field decode
    assign gap_sel = {strobe_gap_select_high[`RSS_BIT_GAP_NINE], strobe_gap_select_low}; // see R2
    assign powerdown_gap_multiplier = strobe_gap_select_high[`RSS_BIT_PD_MULT];
    assign slot[0] = buck_rail_slot_assign[`RSS_FIRST_SLOT_MSB:`RSS_FIRST_SLOT_LSB]; // see R10
    assign slot[1] = buck_rail_slot_assign[`RSS_SECOND_SLOT_MSB:`RSS_SECOND_SLOT_LSB]; // see R9

    for (genvar r = 0; r < 2; r++) begin : g_slot
        assign slot_ok[r] = slot[r] >= `RSS_SLOT_MIN && slot[r] <= `RSS_SLOT_MAX; // see R7 R8
    end

    // Sequencer state and strobe stepping
    always_comb begin
        next_state = state;
        next_strobe = o_strobe_num;
        strobe_fire = 1'b0;
        gap_load = 1'b0;
        gap_idx = 4'h1;
        case (state)
            RSS_OFF: begin
                if (pwr_on) begin
                    next_strobe = `RSS_STROBE_FIRST;
                    strobe_fire = 1'b1;
                    gap_load = 1'b1;
                    gap_idx = `RSS_STROBE_FIRST;
                    next_state = RSS_UP;
                end
            end
            RSS_UP: begin
                if (gap_done) begin
                    next_strobe = o_strobe_num + 4'h1; // see R15
                    strobe_fire = 1'b1;
                    if (next_strobe == `RSS_STROBE_LAST) begin
                        next_state = RSS_ON;
                    end else begin
                        gap_load = 1'b1;
                        gap_idx = next_strobe;
                    end
                end
            end
            RSS_ON: begin
                if (!pwr_on) begin
                    next_strobe = `RSS_STROBE_LAST;
                    strobe_fire = 1'b1;
                    gap_load = 1'b1;
                    gap_idx = `RSS_STROBE_LAST - 4'h1;
                    next_state = RSS_DOWN;
                end
            end
            RSS_DOWN: begin
                if (gap_done) begin
                    next_strobe = o_strobe_num - 4'h1; // see R15
                    strobe_fire = 1'b1;
                    if (next_strobe == `RSS_STROBE_FIRST) begin
                        next_state = RSS_OFF;
                    end else begin
                        gap_load = 1'b1;
                        gap_idx = next_strobe - 4'h1;
                    end
                end
            end
            default: begin
                next_state = RSS_OFF;
            end
        endcase
    end

    // Gap length: 2 ms or 5 ms, times ten only on the way down
    always_comb begin
        gap_cyc = gap_sel[gap_idx - 4'h1] ? P_LONG_CYC : P_SHORT_CYC; // see R1 R3
        if (next_state == RSS_DOWN && powerdown_gap_multiplier) begin
            gap_cyc = gap_cyc * PD_FACTOR; // see R4 R5
        end
    end

    rss_gap_timer #(
        .W(32)
    ) u_gap_timer (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_load(gap_load),
        .i_cycles(gap_cyc),
        .o_done(gap_done)
    );

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= RSS_OFF;
            o_strobe_num <= 4'h0;
            o_strobe_pulse <= 1'b0;
            o_seq_busy <= 1'b0;
        end else begin
            state <= next_state;
            o_strobe_num <= next_strobe;
            o_strobe_pulse <= strobe_fire;
            o_seq_busy <= next_state == RSS_UP || next_state == RSS_DOWN;
        end
    end

    // Rail enables follow their slot's strobe
    for (genvar r = 0; r < 2; r++) begin : g_rail
        always_ff @(posedge i_mclk or negedge rst_n) begin
            if (!rst_n) begin
                rail_en[r] <= 1'b0;
            end else if (!slot_ok[r]) begin
                rail_en[r] <= 1'b0; // see R8
            end else if (strobe_fire && next_strobe == slot[r]) begin
                rail_en[r] <= next_state == RSS_UP || next_state == RSS_ON; // see R7 R13
            end
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_first_buck_seq_ctl <= 1'b0;
            o_second_buck_seq_ctl <= 1'b0;
        end else begin
            o_first_buck_seq_ctl <= slot_ok[0];
            o_second_buck_seq_ctl <= slot_ok[1];
        end
    end

    assign o_first_buck_rail_en = rail_en[0];
    assign o_second_buck_rail_en = rail_en[1];

    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    sequence s_up_start_first;
        state == RSS_OFF && pwr_on;
    endsequence

    sequence s_down_start;
        state == RSS_ON && !pwr_on;
    endsequence

    AST_GAP_ONE: assert property (s_up_start_first |-> // see R1
        gap_cyc == (strobe_gap_select_low[0] ? P_LONG_CYC : P_SHORT_CYC))
        else $error("gap after strobe one has wrong length");

    AST_GAP_UP_SEL: assert property (gap_load && next_state == RSS_UP |-> // see R2
        gap_cyc == (gap_sel[next_strobe - 4'h1] ? P_LONG_CYC : P_SHORT_CYC))
        else $error("power-up gap does not follow its select bit");

    AST_GAP_NINE: assert property (gap_load && next_state == RSS_UP && next_strobe == 4'h9 |-> // see R3
        gap_cyc == (strobe_gap_select_high[0] ? P_LONG_CYC : P_SHORT_CYC))
        else $error("gap after strobe nine has wrong length");

    AST_PD_MULT: assert property (s_down_start ##0 powerdown_gap_multiplier |-> // see R4
        gap_cyc == PD_FACTOR * (gap_sel[8] ? P_LONG_CYC : P_SHORT_CYC))
        else $error("power-down gap not multiplied by ten");

    AST_UP_UNSCALED: assert property (gap_load && next_state == RSS_UP |-> // see R5
        gap_cyc <= P_LONG_CYC)
        else $error("power-up gap scaled");

    AST_RSVD_ZERO: assert property (i_reg_addr == `RSS_ADDR_GAP_HIGH |=> // see R6
        o_reg_rdata[6:1] == 6'h00)
        else $error("reserved bits read nonzero");

    AST_RAIL_ON: assert property (strobe_fire && next_state == RSS_UP && slot_ok[0] // see R7
        && next_strobe == slot[0] |=> o_first_buck_rail_en ##1 o_first_buck_rail_en)
        else $error("first buck rail not enabled at its strobe");

    AST_RAIL_FREE: assert property (!slot_ok[1] |=> !o_second_buck_rail_en) // see R8
        else $error("uncontrolled rail driven by sequencer");

    AST_LAST_ON: assert property (state == RSS_UP && gap_done && o_strobe_num == 4'h9 // see R13
        |=> state == RSS_ON && o_strobe_num == 4'ha && o_strobe_pulse)
        else $error("strobe ten not reached at end of power-up");

    AST_LOCKED: assert property (i_reg_wr && !i_unlocked |=> $stable(strobe_gap_select_low) // see R14
        && $stable(strobe_gap_select_high) && $stable(buck_rail_slot_assign))
        else $error("write taken while locked");

    AST_DOWN_STEP: assert property (state == RSS_DOWN && gap_done |=> // see R15
        o_strobe_pulse && o_strobe_num == $past(o_strobe_num) - 4'h1)
        else $error("power-down strobe not descending by one");

    AST_UP_STEP: assert property (state == RSS_UP && gap_done |=> // see R15
        o_strobe_pulse && o_strobe_num == $past(o_strobe_num) + 4'h1)
        else $error("power-up strobe not ascending by one");

    AST_FIRST_FREE: assert property (!slot_ok[0] |=> !o_first_buck_rail_en) // see R8
        else $error("uncontrolled first rail driven by sequencer");
endmodule

//--- rss_cfg.svh
// Constants of the rail strobe sequencer: offsets, fields, reset values, timing
// Functional notes
// R1 - The gap between strobe 1 and strobe 2 is 2 ms when its select bit is 0 and 5 ms when 1.
// R2 - The low select register holds gap selects 1 to 8, gap k at bit k-1, after strobe k.
// R3 - Bit 0 of the high select register picks 2 ms or 5 ms for the gap after strobe 9.
// R4 - Bit 7 of the high select register multiplies every gap by ten during power-down.
// R5 - The power-down multiplier never changes power-up gap timing.
// R6 - Bits 6 to 1 of the high select register read as zero and ignore writes.
// R7 - A rail slot code of 3h to Ah enables that rail at the strobe of the same number.
// R8 - A rail slot code of 0h to 2h or Bh to Fh leaves the rail outside sequencer control.
// R9 - The second buck slot field sits in bits 7 to 4 of the slot assign register.
// R10 - The first buck slot field sits in bits 3 to 0 of the slot assign register.
// R11 - The slot assign register resets to 0x98, second buck at strobe 9, first at 8.
// R12 - Both gap select registers reset to 0x00.
// R13 - Slot code Ah enables the rail at strobe 10, the last one.
// R14 - Writes to all three registers are ignored unless the device is unlocked.
// R15 - Power-up issues strobes ascending with gaps; power-down descends using the multiplier.
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

`define RSS_ADDR_GAP_LOW 8'h20
`define RSS_ADDR_GAP_HIGH 8'h21
`define RSS_ADDR_SLOT 8'h22

`define RSS_RST_GAP_LOW 8'h00
`define RSS_RST_GAP_HIGH 8'h00
`define RSS_RST_SLOT 8'h98

`define RSS_BIT_PD_MULT 7
`define RSS_BIT_GAP_NINE 0
`define RSS_SECOND_SLOT_MSB 7
`define RSS_SECOND_SLOT_LSB 4
`define RSS_FIRST_SLOT_MSB 3
`define RSS_FIRST_SLOT_LSB 0

`define RSS_SLOT_MIN 4'h3
`define RSS_SLOT_MAX 4'ha
`define RSS_STROBE_FIRST 4'h1
`define RSS_STROBE_LAST 4'ha

`define RSS_GAP_SHORT_MS 2
`define RSS_GAP_LONG_MS 5
`define RSS_PD_FACTOR 10
`define RSS_CLK_KHZ 250000

`endif

//--- rss_pkg.sv
// Types of the rail strobe sequencer
package rss_pkg;
    typedef enum logic [1:0] {
        RSS_OFF = 2'b00,
        RSS_UP = 2'b01,
        RSS_ON = 2'b11,
        RSS_DOWN = 2'b10
    } rss_state_t;
    typedef logic [3:0] rss_slot_t;
endpackage

//--- rss_gap_timer.sv
// Down counter that times one gap between strobes
`timescale 1ns/10ps
module rss_gap_timer #(
    parameter int W = 32
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [W-1:0] i_cycles,
    output logic o_done
);
    logic [W-1:0] count;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= '0;
        end else if (i_load) begin
            count <= i_cycles;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_done <= 1'b0;
        end else begin
            o_done <= !i_load && (count == {{(W-1){1'b0}}, 1'b1});
        end
    end
endmodule

//--- rss_rail_model.sv
// Behavioural buck converter: output comes good a fixed ramp time after enable
`timescale 1ns/10ps
module rss_rail_model #(
    parameter int P_RAMP = 8
) (
    input wire logic i_mclk,
    input wire logic i_en,
    output logic o_good
);
    int ramp = 0;
    // Output collapses at once when the enable drops, like a discharged rail
    always @(posedge i_mclk) begin
        if (i_en !== 1'b1) begin
            ramp <= 0;
            o_good <= 1'b0;
        end else if (ramp < P_RAMP) begin
            ramp <= ramp + 1;
        end else begin
            o_good <= 1'b1;
        end
    end
endmodule

//--- rss_sequencer_tb_top.sv
// Self-checking bench of the rail strobe sequencer with two converter models
`timescale 1ns/10ps
module rss_sequencer_tb_top;
    localparam int SC = 20;
    localparam int LC = 50;
    localparam int RAMP = 8;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_power_on = 1'b0;
    logic i_unlocked = 1'b0;
    logic i_reg_wr = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic [7:0] o_reg_rdata;
    logic [3:0] o_strobe_num;
    logic en1, en2, ctl1, ctl2, pulse, busy, good1, good2;
    int bad_count = 0;
    int n_compared = 0;

    rss_sequencer #(.P_SHORT_CYC(SC), .P_LONG_CYC(LC)) rss_sequencer_i (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_power_on(i_power_on),
        .i_unlocked(i_unlocked),
        .i_reg_wr(i_reg_wr),
        .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata),
        .o_first_buck_rail_en(en1),
        .o_second_buck_rail_en(en2),
        .o_first_buck_seq_ctl(ctl1),
        .o_second_buck_seq_ctl(ctl2),
        .o_strobe_pulse(pulse),
        .o_strobe_num(o_strobe_num),
        .o_seq_busy(busy)
    );
    rss_rail_model #(.P_RAMP(RAMP)) rss_rail_model_i (
        .i_mclk(i_mclk), .i_en(en1), .o_good(good1));
    rss_rail_model #(.P_RAMP(RAMP)) rss_rail_model_i2 (
        .i_mclk(i_mclk), .i_en(en2), .o_good(good2));

    initial begin
        forever #2 i_mclk = ~i_mclk;
    end

    task automatic test_done;
        $display("compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        i_reg_addr <= a;
        repeat (2) @(posedge i_mclk);
        #1;
        chk({8'h00, o_reg_rdata}, {8'h00, exp});
    endtask

    // Enable expected once strobe n has been issued
    function automatic logic exp_en(input logic [3:0] s, input int n, input logic up);
        if (s < 4'h3 || s > 4'ha) begin
            return 1'b0;
        end
        return up ? (int'(s) <= n) : (int'(s) < n);
    endfunction

    task automatic run(input logic up, input logic [7:0] lo, input logic [7:0] hi,
                       input logic [7:0] sl);
        int cnt;
        int gap;
        int k;
        int j;
        @(posedge i_mclk);
        i_power_on <= up;
        for (int i = 1; i <= 10; i++) begin
            k = up ? i : 11 - i;
            j = up ? k - 1 : k;
            cnt = 0;
            do begin
                @(posedge i_mclk);
                #1;
                cnt++;
            end while (pulse !== 1'b1 && cnt < 6000);
            chk(16'(o_strobe_num), 16'(k));
            chk(16'(busy), 16'(i < 10));
            chk(16'({en2, en1}), 16'({exp_en(sl[7:4], k, up), exp_en(sl[3:0], k, up)}));
            if (i > 1) begin
                gap = ((j <= 8) ? lo[j-1] : hi[0]) ? LC : SC;
                gap = (!up && hi[7]) ? gap * 10 : gap;
                chk(16'(cnt), 16'(gap + 1));
            end
        end
        repeat (RAMP + 3) @(posedge i_mclk);
        #1;
        chk(16'(busy), 16'h0000);
        chk(16'({good2, good1}), 16'({en2, en1}));
    endtask

    initial begin
        logic [3:0] c;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] sl;
        repeat (12) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (5) @(posedge i_mclk);
        rd(8'h20, 8'h00);
        rd(8'h21, 8'h00);
        rd(8'h22, 8'h98);
        rd(8'h23, 8'h00);
        wr(8'h22, 8'h53);
        rd(8'h22, 8'h98);
        i_unlocked <= 1'b1;
        for (int n = 0; n < 16; n++) begin
            c = 4'(n);
            lo = {c, ~c};
            hi = {c[1], 6'h2a, c[0]};
            sl = {c, 4'hf - c};
            wr(8'h20, lo);
            wr(8'h21, hi);
            wr(8'h22, sl);
            rd(8'h20, lo);
            rd(8'h21, {hi[7], 6'h00, hi[0]});
            rd(8'h22, sl);
            chk(16'({ctl2, ctl1}), 16'({exp_en(sl[7:4], 10, 1'b1), exp_en(sl[3:0], 10, 1'b1)}));
            run(1'b1, lo, hi, sl);
            run(1'b0, lo, hi, sl);
        end
        // Reset in the middle of a power-up
        @(posedge i_mclk);
        i_power_on <= 1'b1;
        repeat (40) @(posedge i_mclk);
        i_resetn <= 1'b0;
        i_power_on <= 1'b0;
        @(posedge i_mclk);
        #1;
        chk(16'({busy, en2, en1}), 16'h0000);
        repeat (11) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (5) @(posedge i_mclk);
        rd(8'h20, 8'h00);
        rd(8'h22, 8'h98);
        test_done;
    end

    initial begin
        repeat (60000) @(posedge i_mclk);
        bad_count++;
        test_done;
    end
endmodule
